// *** sim/ffep_core_chk.sv ***
// assertions on the pipeline core ports
`timescale 1ns/1ps
module ffep_core_chk (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // memory strobes
  input wire logic [13:0] prog_addr,
  input wire logic prog_rd,
  input wire logic data_rd,
  input wire logic data_we,
  // phases and status
  input wire logic phase_one_fetch,
  input wire logic phase_two,
  input wire logic phase_three,
  input wire logic phase_four,
  input wire logic [13:0] pc_value,
  input wire logic [7:0] acc_value,
  input wire logic dummy_cycle
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // single fetch strobe, then quiet
  sequence s_fetch;
    prog_rd ##1 !prog_rd;
  endsequence
  sequence s_rd;
    data_rd && phase_two ##1 !data_rd && phase_two;
  endsequence
  property p_onehot;
    $onehot({phase_one_fetch, phase_two, phase_three, phase_four});
  endproperty
  a_onehot: assert property (p_onehot) else $error("phases not one-hot");
  property p_wrap;
    $rose(phase_one_fetch) |-> $past(phase_four);
  endproperty
  a_wrap: assert property (p_wrap) else $error("phase one not after four");
  property p_order;
    ($rose(phase_two) |-> $past(phase_one_fetch)) and
    ($rose(phase_three) |-> $past(phase_two)) and ($rose(phase_four) |-> $past(phase_three));
  endproperty
  a_order: assert property (p_order) else $error("phase order broken");
  property p_pcinc;
    $rose(phase_one_fetch) |=> pc_value == $past(pc_value) + 14'h0001;
  endproperty
  a_pcinc: assert property (p_pcinc) else $error("counter not stepped");
  property p_rd;
    $rose(phase_one_fetch) |=> s_fetch;
  endproperty
  a_rd: assert property (p_rd) else $error("fetch strobe missing");
  property p_addr;
    prog_rd |-> phase_one_fetch && prog_addr == pc_value - 14'h0001;
  endproperty
  a_addr: assert property (p_addr) else $error("fetch address wrong");
  property p_acc;
    !$stable(acc_value) |-> phase_four;
  endproperty
  a_acc: assert property (p_acc) else $error("acc moved outside phase four");
  property p_we;
    data_we |-> phase_four && !$past(data_we);
  endproperty
  a_we: assert property (p_we) else $error("store out of place");
  property p_drd;
    data_rd |-> s_rd;
  endproperty
  a_drd: assert property (p_drd) else $error("read out of place");
  property p_dummy;
    dummy_cycle |-> !data_rd && !data_we;
  endproperty
  a_dummy: assert property (p_dummy) else $error("dummy slot accessed data");
endmodule

// *** sim/ffep_mem_model.sv ***
// program and data memory model facing the core
`timescale 1ns/1ps
module ffep_mem_model (
  // clock
  input wire logic sys_clk,
  // program side
  input wire logic [13:0] prog_addr,
  input wire logic prog_rd,
  output logic [15:0] prog_data,
  // data side
  input wire logic [11:0] data_addr,
  input wire logic data_rd,
  input wire logic data_we,
  input wire logic [7:0] data_wdata,
  output logic [7:0] data_rdata
);
  logic [15:0] rom [256];
  logic [7:0] ram [256];
  initial begin
    prog_data = 16'h0000;
    data_rdata = 8'h00;
  end
  // answer each strobe on the next edge
  always @(posedge sys_clk) begin
    if (prog_rd) prog_data <= rom[prog_addr[7:0]];
    if (data_rd) data_rdata <= ram[data_addr[7:0]];
    if (data_we) ram[data_addr[7:0]] <= data_wdata;
  end
endmodule

// *** sim/tb_four_phase_fetch_execute_pipeline.sv ***
// testbench for the four phase fetch execute core
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value at %0t: got %h exp %h", $time, g, e); end end
module tb_four_phase_fetch_execute_pipeline;
  logic sys_clk, rst, low_speed_crystal_clock, internal_fast_rc_clock, clk_src_sel;
  logic [13:0] prog_addr, pc_value;
  logic [15:0] prog_data;
  logic [11:0] data_addr;
  logic [7:0] data_wdata, data_rdata, acc_value;
  logic prog_rd, data_rd, data_we, phase_one_fetch, phase_two, phase_three, phase_four;
  logic active_src, dummy_cycle;
  logic [3:0] osc_cnt = 4'h0;
  int num_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  localparam logic [15:0] PRG [26] = '{16'hC03C, 16'h1010, 16'h4011, 16'h7002, 16'h6020,
    16'h9009, 16'hC000, 0, 0, 16'h8012, 16'hC000, 16'hC010, 16'hE000, 16'hC000, 0, 0,
    16'hA018, 16'hC077, 16'h9012, 0, 0, 0, 0, 0, 16'hB000, 16'hC000};
  localparam logic [7:0] FA [20] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
    8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h10, 8'h11, 8'h18, 8'h19, 8'h11, 8'h12, 8'h13, 8'h12};
  localparam logic [7:0] AC [20] = '{8'h00, 8'h3C, 8'h41, 8'hBE, 8'hBF, 8'hBF, 8'hBF,
    8'hBF, 8'hBF, 8'hBF, 8'h10, 8'h10, 8'h10, 8'h10, 8'h10, 8'h10, 8'h10, 8'h77, 8'h77, 8'h77};
  localparam logic [23:0] DM = 24'h12_A500;
  localparam logic [15:0] XPRG [8] = '{16'hD000, 16'h0011, 16'h2010, 16'h7000, 16'h7001,
    16'h7003, 16'h5012, 16'h9007};
  localparam logic [7:0] XAC [8] = '{8'h00, 8'h00, 8'hFF, 8'h05, 8'h82, 8'h05, 8'h04, 8'h00};
  ffep_core u_dut (.sys_clk, .rst, .low_speed_crystal_clock, .internal_fast_rc_clock,
    .clk_src_sel, .prog_addr, .prog_rd, .prog_data, .data_addr, .data_rd, .data_we,
    .data_wdata, .data_rdata, .phase_one_fetch, .phase_two, .phase_three, .phase_four,
    .active_src, .pc_value, .acc_value, .dummy_cycle);
  ffep_mem_model u_mem (.sys_clk, .prog_addr, .prog_rd, .prog_data, .data_addr, .data_rd,
    .data_we, .data_wdata, .data_rdata);
  // clock, oscillator pins and cycle ceiling
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 6000) begin
      num_errors++;
      tally_and_finish();
    end
    #1;
    osc_cnt = osc_cnt + 4'h1;
    low_speed_crystal_clock = osc_cnt[3];
    internal_fast_rc_clock = osc_cnt[2];
  end
  task automatic tally_and_finish();
    if (num_errors == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  function automatic logic ph_of(input int n);
    return (n == 1) ? phase_one_fetch : phase_three;
  endfunction
  // wait for the next entry into phase one or three
  task automatic next_ph(input int n);
    int k;
    k = 0;
    while (ph_of(n) === 1'b1 && k < 300) begin @(posedge sys_clk); k++; end
    while (ph_of(n) !== 1'b1 && k < 300) begin @(posedge sys_clk); k++; end
    if (k >= 300) `CHK(1'b0, 1'b1)
    #1;
  endtask
  task automatic s_reset();
    @(posedge sys_clk);
    #1 rst = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    `CHK({phase_one_fetch, phase_four, dummy_cycle}, 3'h3)
    `CHK({pc_value, acc_value}, 22'h00_0000)
    rst = 1'b0;
  endtask
  task automatic s_prog();
    for (int c = 1; c < 21; c++) begin
      next_ph(1);
      if (c > 1) `CHK(acc_value, AC[c-2])
      next_ph(3);
      `CHK(prog_addr, {6'h00, FA[c-1]})
      `CHK(pc_value, {6'h00, FA[c-1]} + 14'h0001)
      if (c > 1) `CHK(dummy_cycle, DM[c])
    end
    `CHK(u_mem.ram[8'h20], 8'hBF)
  endtask
  // extended load, and, rotates, decrement and plain load from a fresh reset
  task automatic s_ext();
    for (int i = 0; i < 8; i++) u_mem.rom[i] = XPRG[i];
    s_reset();
    for (int c = 1; c < 10; c++) begin
      next_ph(1);
      if (c > 1) `CHK(acc_value, XAC[c-2])
      if (c == 3) `CHK(dummy_cycle, 1'b0)
    end
  endtask
  task automatic s_osc(input logic sel, input int per);
    int t0;
    clk_src_sel = sel;
    next_ph(1);
    next_ph(1);
    t0 = cyc;
    next_ph(1);
    `CHK(cyc - t0, per)
    `CHK(active_src, sel)
  endtask
  initial begin
    rst = 1'b1;
    clk_src_sel = 1'b0;
    low_speed_crystal_clock = 1'b0;
    internal_fast_rc_clock = 1'b0;
    for (int i = 0; i < 26; i++) u_mem.rom[i] = PRG[i];
    u_mem.ram[16] = 8'h05;
    u_mem.ram[17] = 8'hFF;
    u_mem.ram[18] = 8'h00;
    s_reset();
    s_prog();
    s_osc(1'b1, 32);
    s_osc(1'b0, 64);
    s_osc(1'b1, 32);
    s_reset();
    s_prog();
    s_ext();
    tally_and_finish();
  end
endmodule
bind ffep_core ffep_core_chk u_chk (.sys_clk, .rst, .prog_addr, .prog_rd, .data_rd,
  .data_we, .phase_one_fetch, .phase_two, .phase_three, .phase_four, .pc_value,
  .acc_value, .dummy_cycle);

// *** verilog/ffep_core.sv ***
// fetch execute pipeline core with accumulator, 8-bit ALU and stack
`timescale 1ns/1ps
module ffep_core (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // oscillator pins and select
  input wire logic low_speed_crystal_clock,
  input wire logic internal_fast_rc_clock,
  input wire logic clk_src_sel,
  // program memory
  output logic [13:0] prog_addr,
  output logic prog_rd,
  input wire logic [15:0] prog_data,
  // data memory
  output logic [11:0] data_addr,
  output logic data_rd,
  output logic data_we,
  output logic [7:0] data_wdata,
  input wire logic [7:0] data_rdata,
  // phase clocks
  output logic phase_one_fetch,
  output logic phase_two,
  output logic phase_three,
  output logic phase_four,
  // status
  output logic active_src,
  output logic [13:0] pc_value,
  output logic [7:0] acc_value,
  output logic dummy_cycle
);
  ffep_phase_if pif ();

  logic s1, s2, s3, s4;
  logic [13:0] pc_ff, nxt_pc, paddr_ff;
  logic prd_ff;
  logic [15:0] pf_ff, ir_ff;
  logic ext2_ff;
  logic [11:0] ext_addr_ff, daddr_ff;
  logic drd_ff, dwe_ff;
  logic [7:0] dwd_ff, acc_ff, alu_ff;
  logic zero_ff;
  logic dummy_ff;
  logic [3:0] sp_ff;
  logic [13:0] stk_mem [ffep_pkg::STK_D];
  logic [3:0] op, eop;
  logic [1:0] sub;
  logic [7:0] imm;
  logic acc_wr, is_jmp, is_call, is_ret, is_wpcl, is_ext;
  logic skip_hit, br_take, flush, rd_op;
  logic [13:0] br_tgt, ret_addr;
  logic [3:0] sp_dn;

  ffep_phase_gen u_phase (
    .sys_clk(sys_clk),
    .rst(rst),
    .low_speed_crystal_clock(low_speed_crystal_clock),
    .internal_fast_rc_clock(internal_fast_rc_clock),
    .clk_src_sel(clk_src_sel),
    .pif(pif),
    .active_src(active_src)
  );

  // 8-bit ALU shared by arithmetic, logic, rotate and counting operations
  function automatic logic [7:0] ffep_alu(input logic [3:0] o, input logic [1:0] s,
                                          input logic [7:0] a, input logic [7:0] m,
                                          input logic [7:0] k);
    logic [7:0] r;
    r = a;
    case (o)
      ffep_pkg::OP_ADD: r = a + m;
      ffep_pkg::OP_AND: r = a & m;
      ffep_pkg::OP_OR: r = a | m;
      ffep_pkg::OP_XOR: r = a ^ m;
      ffep_pkg::OP_LDA: r = m;
      ffep_pkg::OP_LDI: r = k;
      ffep_pkg::OP_ROT: begin
        case (s)
          ffep_pkg::SUB_RR: r = {a[0], a[7:1]};
          ffep_pkg::SUB_RL: r = {a[6:0], a[7]};
          ffep_pkg::SUB_INC: r = a + ffep_pkg::BYTE_ONE;
          ffep_pkg::SUB_DEC: r = a - ffep_pkg::BYTE_ONE;
          default: r = a;
        endcase
      end
      default: r = a;
    endcase
    return r;
  endfunction

  // one-cycle strobes on entry to each phase
  assign s1 = pif.stb & (pif.ph == ffep_pkg::PH_ONE);
  assign s2 = pif.stb & (pif.ph == ffep_pkg::PH_TWO);
  assign s3 = pif.stb & (pif.ph == ffep_pkg::PH_THREE);
  assign s4 = pif.stb & (pif.ph == ffep_pkg::PH_FOUR);

  // instruction field decode; second half of an extended op acts as a load
  assign op = ir_ff[ffep_pkg::OPC_HI:ffep_pkg::OPC_LO];
  assign eop = ext2_ff ? ffep_pkg::OP_LDA : op;
  assign sub = ir_ff[1:0];
  assign imm = ir_ff[7:0];
  assign is_jmp = (op == ffep_pkg::OP_JMP) & ~ext2_ff;
  assign is_call = (op == ffep_pkg::OP_CALL) & ~ext2_ff;
  assign is_ret = (op == ffep_pkg::OP_RET) & ~ext2_ff;
  assign is_wpcl = (op == ffep_pkg::OP_WPCL) & ~ext2_ff;
  assign is_ext = (op == ffep_pkg::OP_LLDA) & ~ext2_ff;
  assign acc_wr = (eop == ffep_pkg::OP_ADD) | (eop == ffep_pkg::OP_AND) |
                  (eop == ffep_pkg::OP_OR) | (eop == ffep_pkg::OP_XOR) |
                  (eop == ffep_pkg::OP_LDA) | (eop == ffep_pkg::OP_ROT) |
                  (eop == ffep_pkg::OP_LDI);
  // only memory operand ops read data memory; dummy and register ops stay quiet
  assign rd_op = (acc_wr & (eop != ffep_pkg::OP_ROT) & (eop != ffep_pkg::OP_LDI)) |
                 (eop == ffep_pkg::OP_SZ);

  // branch targets and the decision to drop the prefetched word
  assign sp_dn = sp_ff - ffep_pkg::SP_ONE;
  assign ret_addr = pc_ff - ffep_pkg::PC_ONE;
  assign skip_hit = (eop == ffep_pkg::OP_SZ) & zero_ff;
  assign br_take = is_jmp | is_call | is_ret | is_wpcl;
  assign flush = br_take | skip_hit | is_ext;
  always_comb begin
    br_tgt = {pc_ff[13:12], ir_ff[ffep_pkg::TGT_HI:0]};
    if (is_ret) br_tgt = stk_mem[sp_dn];
    if (is_wpcl) br_tgt = {pc_ff[13:ffep_pkg::PAGE_LO], acc_ff};
  end

  // program counter: step in phase one, branch in phase four
  always_comb begin
    nxt_pc = pc_ff;
    if (s1) nxt_pc = pc_ff + ffep_pkg::PC_ONE;
    else if (s4 & br_take) nxt_pc = br_tgt;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pc_ff <= ffep_pkg::PC_RST;
    end else begin
      pc_ff <= nxt_pc;
    end
  end

  // fetch: address issued in phase one, word captured entering phase two
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      paddr_ff <= ffep_pkg::PC_RST;
      prd_ff <= 1'b0;
      pf_ff <= ffep_pkg::NOP_WORD;
    end else begin
      prd_ff <= s1;
      if (s1) paddr_ff <= pc_ff;
      if (s2) pf_ff <= prog_data;
    end
  end

  // instruction register advances at phase four; a flush inserts a dummy
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ir_ff <= ffep_pkg::NOP_WORD;
      dummy_ff <= 1'b1;
    end else if (s4) begin
      ir_ff <= flush ? ffep_pkg::NOP_WORD : pf_ff;
      dummy_ff <= flush & ~is_ext; // second half of an extended op is real work
    end
  end

  // extended op: prefetched word becomes the long data address
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ext2_ff <= 1'b0;
      ext_addr_ff <= 12'h000;
    end else if (s4) begin
      ext2_ff <= is_ext;
      if (is_ext) ext_addr_ff <= pf_ff[11:0];
    end
  end

  // phase two: decode the operand address and start the data read
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      daddr_ff <= 12'h000;
      drd_ff <= 1'b0;
    end else begin
      drd_ff <= s2 & rd_op;
      if (s2) daddr_ff <= ext2_ff ? ext_addr_ff : {ffep_pkg::PAGE_PAD, ir_ff[7:0]};
    end
  end

  // phase three: operand through the ALU
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      alu_ff <= ffep_pkg::ACC_RST;
      zero_ff <= 1'b0;
    end else if (s3) begin
      alu_ff <= ffep_alu(eop, sub, acc_ff, data_rdata, imm);
      zero_ff <= (data_rdata == ffep_pkg::BYTE_ZERO);
    end
  end

  // phase four: accumulator and data memory write back
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      acc_ff <= ffep_pkg::ACC_RST;
      dwe_ff <= 1'b0;
      dwd_ff <= ffep_pkg::ACC_RST;
    end else begin
      dwe_ff <= s4 & (eop == ffep_pkg::OP_STA);
      if (s4 & (eop == ffep_pkg::OP_STA)) dwd_ff <= acc_ff;
      if (s4 & acc_wr) acc_ff <= alu_ff;
    end
  end

  // return stack pointer
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sp_ff <= ffep_pkg::SP_RST;
    end else if (s4 & is_call) begin
      sp_ff <= sp_ff + ffep_pkg::SP_ONE;
    end else if (s4 & is_ret) begin
      sp_ff <= sp_dn;
    end
  end

  // stack storage; a call saves the address of the word after it
  always_ff @(posedge sys_clk) begin
    if (s4 & is_call) stk_mem[sp_ff] <= ret_addr;
  end

  // outputs
  assign prog_addr = paddr_ff;
  assign prog_rd = prd_ff;
  assign data_addr = daddr_ff;
  assign data_rd = drd_ff;
  assign data_we = dwe_ff;
  assign data_wdata = dwd_ff;
  assign phase_one_fetch = (pif.ph == ffep_pkg::PH_ONE);
  assign phase_two = (pif.ph == ffep_pkg::PH_TWO);
  assign phase_three = (pif.ph == ffep_pkg::PH_THREE);
  assign phase_four = (pif.ph == ffep_pkg::PH_FOUR);
  assign pc_value = pc_ff;
  assign acc_value = acc_ff;
  assign dummy_cycle = dummy_ff;
endmodule

// *** verilog/ffep_phase_gen.sv ***
// oscillator select, pin synchronisers and four phase sequencer
`timescale 1ns/1ps
module ffep_phase_gen (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // oscillator pins and select
  input wire logic low_speed_crystal_clock,
  input wire logic internal_fast_rc_clock,
  input wire logic clk_src_sel,
  // phase outputs
  ffep_phase_if.gen pif,
  output logic active_src
);
  logic [1:0] src_in;
  logic [2:0] sy_ff [2];
  logic [1:0] lvl_ff;
  logic [1:0] rise;
  logic sel_ff;
  logic tick;
  ffep_pkg::ffep_phase_e ph_ff;
  ffep_pkg::ffep_phase_e nxt_ph;
  logic stb_ff;

  assign src_in = {internal_fast_rc_clock, low_speed_crystal_clock};

  // three flop synchroniser; a level counts once flops two and three agree
  for (genvar i = 0; i < 2; i++) begin : g_sync
    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        // park high so a pin already high at release gives no false edge
        sy_ff[i] <= 3'h7;
        lvl_ff[i] <= 1'b1;
      end else begin
        sy_ff[i] <= {sy_ff[i][1:0], src_in[i]};
        if (sy_ff[i][2] == sy_ff[i][1]) lvl_ff[i] <= sy_ff[i][2];
      end
    end
    assign rise[i] = (sy_ff[i][2] == sy_ff[i][1]) & sy_ff[i][2] & ~lvl_ff[i];
  end

  // selected oscillator edge drives the sequencer
  assign tick = sel_ff ? rise[1] : rise[0];

  // phase order one, two, three, four, one
  always_comb begin
    case (ph_ff)
      ffep_pkg::PH_ONE: nxt_ph = ffep_pkg::PH_TWO;
      ffep_pkg::PH_TWO: nxt_ph = ffep_pkg::PH_THREE;
      ffep_pkg::PH_THREE: nxt_ph = ffep_pkg::PH_FOUR;
      ffep_pkg::PH_FOUR: nxt_ph = ffep_pkg::PH_ONE;
      default: nxt_ph = ffep_pkg::PH_ONE;
    endcase
  end

  // reset parks in phase four so the first tick opens a fresh phase one
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ph_ff <= ffep_pkg::PH_FOUR;
      stb_ff <= 1'b0;
      sel_ff <= 1'b0;
    end else begin
      sel_ff <= clk_src_sel;
      stb_ff <= tick;
      if (tick) ph_ff <= nxt_ph;
    end
  end

  assign pif.ph = ph_ff;
  assign pif.stb = stb_ff;
  assign active_src = sel_ff;
endmodule

// *** verilog/ffep_phase_if.sv ***
// phase state carried from the phase generator to the core
`timescale 1ns/1ps
interface ffep_phase_if;
  ffep_pkg::ffep_phase_e ph;
  logic stb;
  modport gen (output ph, output stb);
  modport core (input ph, input stb);
endinterface

// *** verilog/ffep_pkg.sv ***
// constants and types for the four phase fetch execute pipeline
// Overview of operation
// - system timing comes from the slow crystal or fast RC oscillator, selectable
// - four non-overlapping phases derived from the clock; one pass is one cycle
// - program counter increments at phase one start; instruction fetched in phase one
// - decode and execute happen during phases two, three and four
// - next fetch overlaps current execution giving one instruction per cycle
// - standard instructions take one cycle, extended instructions take two
// - instructions changing the program counter take one extra cycle
// - jumps use one cycle to get the target and another to branch
// - an 8-bit ALU does arithmetic, logic, rotate, increment, decrement, branch tests
// - operands and results move through the accumulator and the ALU
// - a met skip discards the prefetched instruction and runs a dummy cycle
// - writing the counter low byte jumps within the 256-word page plus dummy cycle
package ffep_pkg;
  localparam int PC_W = 14;
  localparam int DA_W = 12;
  localparam int IW = 16;
  localparam int DW = 8;
  localparam int STK_D = 16;
  localparam int SP_W = 4;
  localparam logic [13:0] PC_RST = 14'h0000;
  localparam logic [13:0] PC_ONE = 14'h0001;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [15:0] NOP_WORD = 16'h0000;
  localparam logic [3:0] SP_RST = 4'h0;
  localparam logic [3:0] SP_ONE = 4'h1;
  localparam logic [3:0] PAGE_PAD = 4'h0;
  // opcode field is bits 15:12, operand byte 7:0, jump target 11:0
  localparam int OPC_HI = 15;
  localparam int OPC_LO = 12;
  localparam int TGT_HI = 11;
  localparam int PAGE_LO = 8;
  localparam logic [3:0] OP_NOP = 4'h0;
  localparam logic [3:0] OP_ADD = 4'h1;
  localparam logic [3:0] OP_AND = 4'h2;
  localparam logic [3:0] OP_OR = 4'h3;
  localparam logic [3:0] OP_XOR = 4'h4;
  localparam logic [3:0] OP_LDA = 4'h5;
  localparam logic [3:0] OP_STA = 4'h6;
  localparam logic [3:0] OP_ROT = 4'h7;
  localparam logic [3:0] OP_SZ = 4'h8;
  localparam logic [3:0] OP_JMP = 4'h9;
  localparam logic [3:0] OP_CALL = 4'hA;
  localparam logic [3:0] OP_RET = 4'hB;
  localparam logic [3:0] OP_LDI = 4'hC;
  localparam logic [3:0] OP_LLDA = 4'hD;
  localparam logic [3:0] OP_WPCL = 4'hE;
  // sub-operations of OP_ROT in bits 1:0
  localparam logic [1:0] SUB_RR = 2'h0;
  localparam logic [1:0] SUB_RL = 2'h1;
  localparam logic [1:0] SUB_INC = 2'h2;
  localparam logic [1:0] SUB_DEC = 2'h3;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  typedef enum logic [3:0] {
    PH_ONE = 4'h1,
    PH_TWO = 4'h2,
    PH_THREE = 4'h4,
    PH_FOUR = 4'h8
  } ffep_phase_e;
endpackage
